// [src/load_exec_regs.svh]
// register offsets, field positions and response codes of the load datapath
`ifndef LOAD_EXEC_REGS_SVH
`define LOAD_EXEC_REGS_SVH

`define CTRL_OFFSET    8'h00
`define OPCODE_OFFSET  8'h04
`define INSTR_OFFSET   8'h08
`define OPHI_OFFSET    8'h0c
`define OPLO_OFFSET    8'h10
`define EADDR_OFFSET   8'h14
`define REAL_OFFSET    8'h18
`define STATUS_OFFSET  8'h1c
`define IRQSTAT_OFFSET 8'h20
`define IRQMASK_OFFSET 8'h24
`define GPR_BASE       8'h40
`define GPR_TOP        8'h5c

`define CTRL_START     0
`define CTRL_CARRY     1
`define CTRL_MODE_LO   2
`define CTRL_MODE_HI   3
`define STAT_BUSY      0
`define STAT_CC_LO     4
`define CC1            3
`define CC2            2
`define CC3            1
`define CC4            0
`define IRQ_DONE       0
`define IRQ_OVF        1

`define MASK_REG       3'h4
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define NEG_LIMIT      32'h80000000

`endif

// [src/load_exec_pkg.sv]
// types shared by the load datapath
package load_exec_pkg;
    typedef enum logic [2:0] {
        LOAD_MASKED_DOUBLE,
        LOAD_NEGATED_BYTE,
        LOAD_NEGATED_HALF,
        LOAD_NEGATED_WORD,
        LOAD_NEGATED_DOUBLE,
        LOAD_SIGN_EXT_IMMEDIATE,
        LOAD_EFF_ADDR,
        LOAD_REAL_ADDR
    } op_type;
    typedef enum logic [1:0] {
        MODE_512KB,
        LEGACY_STATUS_WORD_MODE,
        STATUS_DOUBLEWORD_MODE
    } mode_type;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOW,
        ST_HIGH
    } state_type;
endpackage

// [src/load_negate_mask_address_exec.sv]
// load negate, masked, immediate and address datapath with axi4-lite regs
`timescale 1ns/10ps
`include "load_exec_regs.svh"

// Operation
// - masked double ands words with mask_register, low first
// - doubleword condition from signed 64-bit pair
// - negated byte: zero-extend then negate
// - negated byte clears bits one, two
// - negated half: sign-extend then negate
// - non-address word result sets one of two/three/four
// - negated word writes two's complement
// - negation overflow sets condition bit one
// - negated double low to R+1, high R
// - immediate sign-extends instruction low halfword
// - effective address to low bits, cc kept
// - extended modes clear 2-7, address 8-31
// - 512KB no indirect/index copies instruction
// - indexed 512KB sums upper twelve bits
// - indirect 512KB sums final word fields
// - address overflow may add bit eleven
// - real address into 7-31, clear 0-6
module load_negate_mask_address_exec
    import load_exec_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // axi4-lite write address and data
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // axi4-lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // axi4-lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // interrupt
    output logic             irqOut
);
    logic [31:0] gprQ [8];
    logic [31:0] instrQ, opHiQ, opLoQ, eaddrQ, realQ;
    logic [3:0]  ccQ;
    logic [1:0]  irqStatQ, irqMaskQ;
    logic        carryQ;
    mode_type    modeQ;
    op_type      opQ;
    state_type   stateQ;
    logic        awHeldQ, wHeldQ;
    logic [7:0]  awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0]  wStrbQ;
    logic        doWrite, busy, startReq;
    logic [2:0]  rIdx, rPair, xIdx, xInd;
    logic [31:0] loResult, hiResult, wordResult, leaResult, strbData;
    logic [63:0] dblResult;
    logic [11:0] idxHigh, baseHigh;
    logic [31:0] idxWord;
    logic        wordOvf, dblOvf, isDouble, mapped;

    function automatic logic [3:0] cond_word(input logic [31:0] v);
        cond_word = {1'b0, ~v[31] && v != 32'h0, v[31], v == 32'h0};
    endfunction

    assign busy     = stateQ != ST_IDLE;
    assign rIdx     = instrQ[25:23];
    assign rPair    = 3'(rIdx + 3'h1);
    assign xIdx     = instrQ[22:20];
    assign xInd     = opHiQ[22:20];
    assign isDouble = opQ == LOAD_MASKED_DOUBLE || opQ == LOAD_NEGATED_DOUBLE;
    assign doWrite  = awHeldQ && wHeldQ && !s_axi_bvalid;
    assign startReq = doWrite && awAddrQ == `CTRL_OFFSET && wStrbQ[0]
                      && wDataQ[`CTRL_START] && !busy;
    assign strbData = {wStrbQ[3] ? wDataQ[31:24] : 8'h0,
                       wStrbQ[2] ? wDataQ[23:16] : 8'h0,
                       wStrbQ[1] ? wDataQ[15:8]  : 8'h0,
                       wStrbQ[0] ? wDataQ[7:0]   : 8'h0};

    // datapath; operands stay frozen while busy so one mux serves all steps
    assign dblResult = 64'(-{opHiQ, opLoQ});
    assign dblOvf    = {opHiQ, opLoQ} == {`NEG_LIMIT, 32'h0};
    assign wordOvf   = opHiQ == `NEG_LIMIT;
    assign idxWord   = instrQ[19] ? (xInd == 3'h0 ? 32'h0 : gprQ[xInd])
                       : gprQ[xIdx];
    assign idxHigh   = idxWord[31:20];
    assign baseHigh  = instrQ[19] ? opHiQ[31:20] : instrQ[31:20];
    // carry out of the low address sum is supplied with the request
    always_comb begin
        if (modeQ != MODE_512KB) begin
            leaResult = {gprQ[rIdx][31:30], 6'h0, eaddrQ[23:0]};
        end else if (!instrQ[19] && xIdx == 3'h0) begin
            leaResult = instrQ;
        end else begin
            leaResult = {12'(baseHigh + idxHigh + {11'h0, carryQ}),
                         eaddrQ[19:0]};
        end
    end
    always_comb begin
        case (opQ)
            LOAD_NEGATED_BYTE:       wordResult = 32'(-{24'h0, opHiQ[7:0]});
            LOAD_NEGATED_HALF:       wordResult =
                32'(-{{16{opHiQ[15]}}, opHiQ[15:0]});
            LOAD_NEGATED_WORD:       wordResult = 32'(-opHiQ);
            LOAD_SIGN_EXT_IMMEDIATE: wordResult =
                {{16{instrQ[15]}}, instrQ[15:0]};
            LOAD_EFF_ADDR:           wordResult = leaResult;
            LOAD_REAL_ADDR:          wordResult = {7'h0, realQ[24:0]};
            default:                 wordResult = 32'h0;
        endcase
    end
    assign loResult = opQ == LOAD_MASKED_DOUBLE ? opLoQ & gprQ[`MASK_REG]
                      : dblResult[31:0];
    assign hiResult = opQ == LOAD_MASKED_DOUBLE ? opHiQ & gprQ[`MASK_REG]
                      : dblResult[63:32];

    // sequencer: low word lands first, high word one cycle later
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stateQ <= ST_IDLE;
        end else begin
            case (stateQ)
                ST_IDLE: if (startReq) stateQ <= ST_LOW;
                ST_LOW:  stateQ <= isDouble ? ST_HIGH : ST_IDLE;
                default: stateQ <= ST_IDLE;
            endcase
        end
    end

    // general registers: bus writes only while idle
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 8; i++) gprQ[i] <= 32'h0;
        end else if (stateQ == ST_LOW) begin
            if (isDouble) gprQ[rPair] <= loResult;
            else gprQ[rIdx] <= wordResult;
        end else if (stateQ == ST_HIGH) begin
            gprQ[rIdx] <= hiResult;
        end else if (doWrite && awAddrQ >= `GPR_BASE
                     && awAddrQ <= `GPR_TOP) begin
            gprQ[awAddrQ[4:2]] <= strbData;
        end
    end

    // condition bits
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ccQ <= 4'h0;
        end else if (stateQ == ST_LOW && !isDouble) begin
            case (opQ)
                LOAD_NEGATED_BYTE:
                    ccQ <= {2'b00, wordResult[31],
                            wordResult == 32'h0};
                LOAD_NEGATED_WORD:
                    ccQ <= cond_word(wordResult)
                           | {wordOvf, 3'h0};
                LOAD_EFF_ADDR, LOAD_REAL_ADDR: ccQ <= ccQ;
                default: ccQ <= cond_word(wordResult);
            endcase
        end else if (stateQ == ST_HIGH) begin
            ccQ <= {opQ == LOAD_NEGATED_DOUBLE && dblOvf,
                    ~hiResult[31] && {hiResult, gprQ[rPair]} != 64'h0,
                    hiResult[31],
                    {hiResult, gprQ[rPair]} == 64'h0};
        end
    end

    // operand and control registers, frozen while busy
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            instrQ <= 32'h0;
            opHiQ <= 32'h0;
            opLoQ <= 32'h0;
            eaddrQ <= 32'h0;
            realQ <= 32'h0;
            opQ <= LOAD_MASKED_DOUBLE;
            modeQ <= MODE_512KB;
            carryQ <= 1'b0;
            irqMaskQ <= 2'h0;
        end else if (doWrite && !busy) begin
            if (awAddrQ == `CTRL_OFFSET) begin
                carryQ <= strbData[`CTRL_CARRY];
                modeQ <= mode_type'(strbData[`CTRL_MODE_HI:`CTRL_MODE_LO]);
            end else if (awAddrQ == `OPCODE_OFFSET) begin
                opQ <= op_type'(strbData[2:0]);
            end else if (awAddrQ == `INSTR_OFFSET) begin
                instrQ <= strbData;
            end else if (awAddrQ == `OPHI_OFFSET) begin
                opHiQ <= strbData;
            end else if (awAddrQ == `OPLO_OFFSET) begin
                opLoQ <= strbData;
            end else if (awAddrQ == `EADDR_OFFSET) begin
                eaddrQ <= strbData;
            end else if (awAddrQ == `REAL_OFFSET) begin
                realQ <= strbData;
            end else if (awAddrQ == `IRQMASK_OFFSET) begin
                irqMaskQ <= strbData[1:0];
            end
        end
    end

    // sticky events: a set in the same cycle as a clear wins
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqStatQ <= 2'h0;
        end else begin
            irqStatQ <= (irqStatQ & ~((doWrite && awAddrQ == `IRQSTAT_OFFSET)
                                      ? strbData[1:0] : 2'h0))
                        | {(stateQ == ST_LOW && opQ == LOAD_NEGATED_WORD
                            && wordOvf) || (stateQ == ST_HIGH
                            && opQ == LOAD_NEGATED_DOUBLE && dblOvf),
                           (stateQ == ST_LOW && !isDouble)
                           || stateQ == ST_HIGH};
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) irqOut <= 1'b0;
        else irqOut <= |(irqStatQ & irqMaskQ);
    end

    // axi write channels, taken in either order
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            awHeldQ <= 1'b0;
            wHeldQ <= 1'b0;
            awAddrQ <= 8'h0;
            wDataQ <= 32'h0;
            wStrbQ <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeldQ <= 1'b1;
                awAddrQ <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeldQ <= 1'b1;
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeldQ <= 1'b0;
                wHeldQ <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign mapped = awAddrQ <= `IRQMASK_OFFSET
                    || (awAddrQ >= `GPR_BASE && awAddrQ <= `GPR_TOP);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !awHeldQ && !(s_axi_awvalid && s_axi_awready)
                             && !s_axi_bvalid;
            s_axi_wready <= !wHeldQ && !(s_axi_wvalid && s_axi_wready)
                            && !s_axi_bvalid;
        end
    end

    // axi read channel
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                if (s_axi_araddr[7:2] == `CTRL_OFFSET >> 2) begin
                    s_axi_rdata <= {28'h0, 2'(modeQ), carryQ, 1'b0};
                end else if (s_axi_araddr[7:2] == `OPCODE_OFFSET >> 2) begin
                    s_axi_rdata <= {29'h0, 3'(opQ)};
                end else if (s_axi_araddr[7:2] == `INSTR_OFFSET >> 2) begin
                    s_axi_rdata <= instrQ;
                end else if (s_axi_araddr[7:2] == `OPHI_OFFSET >> 2) begin
                    s_axi_rdata <= opHiQ;
                end else if (s_axi_araddr[7:2] == `OPLO_OFFSET >> 2) begin
                    s_axi_rdata <= opLoQ;
                end else if (s_axi_araddr[7:2] == `EADDR_OFFSET >> 2) begin
                    s_axi_rdata <= eaddrQ;
                end else if (s_axi_araddr[7:2] == `REAL_OFFSET >> 2) begin
                    s_axi_rdata <= realQ;
                end else if (s_axi_araddr[7:2] == `STATUS_OFFSET >> 2) begin
                    s_axi_rdata <= {24'h0, ccQ, 3'h0, busy};
                end else if (s_axi_araddr[7:2] == `IRQSTAT_OFFSET >> 2) begin
                    s_axi_rdata <= {30'h0, irqStatQ};
                end else if (s_axi_araddr[7:2] == `IRQMASK_OFFSET >> 2) begin
                    s_axi_rdata <= {30'h0, irqMaskQ};
                end else if (s_axi_araddr >= `GPR_BASE
                             && s_axi_araddr <= `GPR_TOP + 8'h3) begin
                    s_axi_rdata <= gprQ[s_axi_araddr[4:2]];
                end else begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence lowStep(op_type o);
        stateQ == ST_LOW && opQ == o;
    endsequence
    sequence maskedPair;
        gprQ[rPair] == (opLoQ & gprQ[`MASK_REG])
        ##1 gprQ[rIdx] == (opHiQ & gprQ[`MASK_REG]);
    endsequence

    masked_pair_a: assert property (lowStep(LOAD_MASKED_DOUBLE)
        ##0 rIdx != `MASK_REG |=> maskedPair)
        else $error("masked doubleword result wrong");
    neg_byte_a: assert property (lowStep(LOAD_NEGATED_BYTE) |=>
        gprQ[rIdx] == 32'(-{24'h0, opHiQ[7:0]}) && ccQ[3:2] == 2'b00)
        else $error("negated byte result or cc wrong");
    neg_double_a: assert property (lowStep(LOAD_NEGATED_DOUBLE)
        |-> ##2 {gprQ[rIdx], gprQ[rPair]} == 64'(-{opHiQ, opLoQ}))
        else $error("doubleword negation wrong");
    word_ovf_a: assert property (lowStep(LOAD_NEGATED_WORD)
        ##0 opHiQ == `NEG_LIMIT |=> ccQ[`CC1] ##1 irqStatQ[`IRQ_OVF])
        else $error("overflow not flagged");
    imm_cc_a: assert property (lowStep(LOAD_SIGN_EXT_IMMEDIATE)
        |=> $onehot(ccQ[2:0]) && !ccQ[`CC1]
        && gprQ[rIdx] == {{16{instrQ[15]}}, instrQ[15:0]})
        else $error("immediate load wrong");
    lea_cc_a: assert property (lowStep(LOAD_EFF_ADDR) |=> $stable(ccQ))
        else $error("address load changed cc");
    real_addr_a: assert property (lowStep(LOAD_REAL_ADDR) |=>
        gprQ[rIdx][31:25] == 7'h0 && gprQ[rIdx][24:0] == realQ[24:0])
        else $error("real address load wrong");
    dbl_cc_a: assert property (stateQ == ST_HIGH |=>
        ccQ[`CC3] == gprQ[rIdx][31]
        && ccQ[`CC4] == ({gprQ[rIdx], gprQ[rPair]} == 64'h0))
        else $error("doubleword cc wrong");
    irq_out_a: assert property (|(irqStatQ & irqMaskQ) |=> irqOut)
        else $error("interrupt not raised");
endmodule

// [dv/operand_mem_model.sv]
// operand memory model that supplies the words the bench loads
`timescale 1ns/10ps
module operand_mem_model (
    // word lookup
    input  wire logic [3:0]  wordIdx,
    output logic      [31:0] wordData
);
    logic [31:0] memArray [16];
    // a doubleword is an even index (high word) then an odd one (low word)
    initial begin
        memArray = '{32'h00000000, 32'h00000001, 32'hae69d10c, 32'h1234f0f0,
            32'h185e0076, 32'h80000000, 32'h0000003a, 32'h0000930c,
            32'h80000000, 32'h00000000, 32'h00ff0001, 32'h55000000,
            32'h00300000, 32'h00000000, 32'h5a5a5a5a, 32'ha5a5a5a5};
    end
    assign wordData = memArray[wordIdx];
endmodule

// [dv/load_negate_mask_address_exec_tb.sv]
// self-checking bench for the load datapath over axi4-lite
`timescale 1ns/10ps
`include "load_exec_regs.svh"
module load_negate_mask_address_exec_tb;
    import load_exec_pkg::*;
    logic        core_clk, sys_rst, irqOut;
    logic        awValid, wValid, bReady, arValid, rReady;
    logic        awReady, wReady, bValid, arReady, rValid;
    logic [7:0]  awAddr, arAddr;
    logic [31:0] wData, rData, memData;
    logic [1:0]  bResp, rResp, lastResp;
    logic [3:0]  memIdx;
    int          n_fail, n_compared, cycles;

    load_negate_mask_address_exec u_load_negate_mask_address_exec (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_awaddr(awAddr), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_bresp(bResp), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_araddr(arAddr),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .irqOut(irqOut));
    operand_mem_model u_operand_mem_model (.wordIdx(memIdx),
        .wordData(memData));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic print_verdict();
        if (n_fail == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // the ceiling is far above the fewer than one thousand cycles needed
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic check(input string n, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic gotA, gotW;
        gotA = 1'b0;
        gotW = 1'b0;
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        while (!(gotA && gotW)) begin
            @(posedge core_clk);
            if (awValid && awReady === 1'b1) begin
                gotA = 1'b1;
                awValid <= 1'b0;
            end
            if (wValid && wReady === 1'b1) begin
                gotW = 1'b1;
                wValid <= 1'b0;
            end
        end
        bReady <= 1'b1;
        @(posedge core_clk);
        while (bValid !== 1'b1)
            @(posedge core_clk);
        lastResp = bResp;
        bReady <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        arAddr <= a;
        arValid <= 1'b1;
        @(posedge core_clk);
        while (arReady !== 1'b1)
            @(posedge core_clk);
        arValid <= 1'b0;
        rReady <= 1'b1;
        @(posedge core_clk);
        while (rValid !== 1'b1)
            @(posedge core_clk);
        d = rData;
        lastResp = rResp;
        rReady <= 1'b0;
    endtask

    function automatic logic [31:0] iw(logic [2:0] r, x, logic i,
                                       logic [18:0] low);
        return {6'h00, r, x, i, low};
    endfunction

    // operands come from the memory model, low word fetched first
    task automatic run_op(input op_type op, input logic [31:0] instr,
                          input logic [3:0] hiIdx, loIdx, ctrl);
        logic [31:0] hiW, loW, st;
        memIdx <= loIdx;
        @(posedge core_clk);
        loW = memData;
        memIdx <= hiIdx;
        @(posedge core_clk);
        hiW = memData;
        wr(`OPCODE_OFFSET, {29'h0, op});
        wr(`INSTR_OFFSET, instr);
        wr(`OPHI_OFFSET, hiW);
        wr(`OPLO_OFFSET, loW);
        wr(`CTRL_OFFSET, {28'h0, ctrl | 4'h1});
        st = 32'h1;
        while (st[`STAT_BUSY] !== 1'b0)
            rd(`STATUS_OFFSET, st);
    endtask

    task automatic reg_is(input string n, input logic [7:0] a,
                          input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        check(n, v, e);
    endtask

    task automatic cc_is(input logic [3:0] e);
        logic [31:0] st;
        rd(`STATUS_OFFSET, st);
        check("cond", {28'h0, st[7:4]}, {28'h0, e});
    endtask

    task automatic t_reset_map();
        logic [31:0] v;
        reg_is("status", `STATUS_OFFSET, 32'h0);
        reg_is("irqstat", `IRQSTAT_OFFSET, 32'h0);
        check("irq", {31'h0, irqOut}, 32'h0);
        rd(8'h30, v);
        check("unmapped rresp", {30'h0, lastResp}, {30'h0, `RESP_SLVERR});
        check("unmapped rdata", v, 32'h0);
        wr(8'h34, 32'h1);
        check("unmapped bresp", {30'h0, lastResp}, {30'h0, `RESP_SLVERR});
    endtask

    task automatic t_negate_single();
        run_op(LOAD_NEGATED_BYTE, iw(3'd1, 3'd0, 1'b0, 19'h0), 4'd6, 4'd13, 4'h0);
        reg_is("gpr1", `GPR_BASE + 8'h04, 32'hffffffc6);
        cc_is(4'b0010);
        run_op(LOAD_NEGATED_BYTE, iw(3'd1, 3'd0, 1'b0, 19'h0), 4'd11, 4'd13, 4'h0);
        reg_is("gpr1", `GPR_BASE + 8'h04, 32'h0);
        cc_is(4'b0001);
        run_op(LOAD_NEGATED_HALF, iw(3'd5, 3'd0, 1'b0, 19'h0), 4'd7, 4'd13, 4'h0);
        reg_is("gpr5", `GPR_BASE + 8'h14, 32'h00006cf4);
        cc_is(4'b0100);
        run_op(LOAD_NEGATED_HALF, iw(3'd5, 3'd0, 1'b0, 19'h0), 4'd10, 4'd13, 4'h0);
        reg_is("gpr5", `GPR_BASE + 8'h14, 32'hffffffff);
        run_op(LOAD_NEGATED_WORD, iw(3'd5, 3'd0, 1'b0, 19'h0), 4'd4, 4'd13, 4'h0);
        reg_is("gpr5", `GPR_BASE + 8'h14, 32'he7a1ff8a);
        cc_is(4'b0010);
        run_op(LOAD_NEGATED_WORD, iw(3'd5, 3'd0, 1'b0, 19'h0), 4'd5, 4'd13, 4'h0);
        reg_is("gpr5", `GPR_BASE + 8'h14, 32'h80000000);
        cc_is(4'b1010);
        reg_is("irqstat", `IRQSTAT_OFFSET, 32'h3);
        run_op(LOAD_SIGN_EXT_IMMEDIATE, iw(3'd3, 3'd7, 1'b1, 19'h70005), 4'd13, 4'd13, 4'h0);
        reg_is("gpr3", `GPR_BASE + 8'h0c, 32'h00000005);
        cc_is(4'b0100);
    endtask

    // doubles always name an even register so the pair is aligned
    task automatic t_double();
        run_op(LOAD_NEGATED_DOUBLE, iw(3'd2, 3'd0, 1'b0, 19'h0), 4'd0, 4'd1, 4'h0);
        reg_is("gpr2", `GPR_BASE + 8'h08, 32'hffffffff);
        reg_is("gpr3", `GPR_BASE + 8'h0c, 32'hffffffff);
        cc_is(4'b0010);
        run_op(LOAD_NEGATED_DOUBLE, iw(3'd2, 3'd0, 1'b0, 19'h0), 4'd8, 4'd9, 4'h0);
        reg_is("gpr2", `GPR_BASE + 8'h08, 32'h80000000);
        reg_is("gpr3", `GPR_BASE + 8'h0c, 32'h0);
        cc_is(4'b1010);
        wr(`GPR_BASE + 8'h10, 32'h3f3f3f3f);
        run_op(LOAD_MASKED_DOUBLE, iw(3'd6, 3'd0, 1'b0, 19'h0), 4'd2, 4'd3, 4'h0);
        reg_is("gpr6", `GPR_BASE + 8'h18, 32'h2e29110c);
        reg_is("gpr7", `GPR_BASE + 8'h1c, 32'h12343030);
        cc_is(4'b0100);
        run_op(LOAD_MASKED_DOUBLE, iw(3'd6, 3'd0, 1'b0, 19'h0), 4'd9, 4'd13, 4'h0);
        cc_is(4'b0001);
    endtask

    task automatic t_address();
        run_op(LOAD_SIGN_EXT_IMMEDIATE, iw(3'd1, 3'd0, 1'b0, 19'h0fffb), 4'd13, 4'd13, 4'h0);
        reg_is("gpr1", `GPR_BASE + 8'h04, 32'hfffffffb);
        cc_is(4'b0010);
        run_op(LOAD_EFF_ADDR, iw(3'd1, 3'd0, 1'b0, 19'h04000), 4'd13, 4'd13, 4'h0);
        reg_is("gpr1", `GPR_BASE + 8'h04, iw(3'd1, 3'd0, 1'b0, 19'h04000));
        cc_is(4'b0010);
        wr(`GPR_BASE + 8'h08, 32'hffffffff);
        wr(`EADDR_OFFSET, 32'h00123456);
        run_op(LOAD_EFF_ADDR, iw(3'd2, 3'd0, 1'b0, 19'h0), 4'd13, 4'd13, 4'h8);
        reg_is("gpr2", `GPR_BASE + 8'h08, 32'hc0123456);
        // legacy extended mode takes the same path as status doubleword
        wr(`EADDR_OFFSET, 32'h00654321);
        run_op(LOAD_EFF_ADDR, iw(3'd2, 3'd0, 1'b0, 19'h0), 4'd13, 4'd13,
               4'h4);
        reg_is("gpr2", `GPR_BASE + 8'h08, 32'hc0654321);
        wr(`GPR_BASE + 8'h0c, 32'h00500000);
        wr(`EADDR_OFFSET, 32'h000abcde);
        run_op(LOAD_EFF_ADDR, iw(3'd1, 3'd3, 1'b0, 19'h0), 4'd13, 4'd13, 4'h2);
        reg_is("gpr1", `GPR_BASE + 8'h04, 32'h011abcde);
        wr(`EADDR_OFFSET, 32'h00000010);
        run_op(LOAD_EFF_ADDR, iw(3'd1, 3'd0, 1'b1, 19'h0), 4'd12, 4'd13, 4'h0);
        reg_is("gpr1", `GPR_BASE + 8'h04, 32'h00800010);
        wr(`REAL_OFFSET, 32'hfe012345);
        run_op(LOAD_REAL_ADDR, iw(3'd2, 3'd0, 1'b0, 19'h0), 4'd13, 4'd13, 4'h0);
        reg_is("gpr2", `GPR_BASE + 8'h08, 32'h00012345);
        cc_is(4'b0010);
    endtask

    // irqOut lags the status or mask change by one registered cycle
    task automatic t_irq();
        wr(`IRQSTAT_OFFSET, 32'h3);
        reg_is("irqstat", `IRQSTAT_OFFSET, 32'h0);
        run_op(LOAD_NEGATED_WORD, iw(3'd5, 3'd0, 1'b0, 19'h0), 4'd4, 4'd13, 4'h0);
        reg_is("irqstat", `IRQSTAT_OFFSET, 32'h1);
        check("irq masked", {31'h0, irqOut}, 32'h0);
        wr(`IRQMASK_OFFSET, 32'h1);
        repeat (2) @(posedge core_clk);
        check("irq raised", {31'h0, irqOut}, 32'h1);
        wr(`IRQSTAT_OFFSET, 32'h1);
        repeat (2) @(posedge core_clk);
        check("irq cleared", {31'h0, irqOut}, 32'h0);
    endtask

    initial begin
        sys_rst = 1'b1;
        {awValid, wValid, bReady, arValid, rReady} = 5'h00;
        awAddr = 8'h00;
        arAddr = 8'h00;
        wData = 32'h0;
        memIdx = 4'h0;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        t_reset_map();
        t_negate_single();
        t_double();
        t_address();
        t_irq();
        print_verdict();
    end
endmodule
